// ===== pcm_port_pkg.sv
// shared types and constants for the pcm highway port a timing block
// assumes one clock (mclk) that is both system clock and pcm bit clock
package pcm_port_pkg;

  // channels served by the port
  localparam int NUM_CH = 4;

  // frame counter width, covers the longest frame (1024 bits) with room
  localparam int FCNT_W = 11;
  localparam logic [FCNT_W-1:0] FCNT_MAX = 11'h7ff;
  localparam logic [FCNT_W-1:0] FCNT_RST = 11'h000;

  // bit clocks per 8 khz frame for each accepted master clock rate
  localparam logic [FCNT_W-1:0] PER_1536 = 11'h0c0; // 192 bits
  localparam logic [FCNT_W-1:0] PER_1544 = 11'h0c1; // 193 bits
  localparam logic [FCNT_W-1:0] PER_2048 = 11'h100; // 256 bits
  localparam logic [FCNT_W-1:0] PER_4096 = 11'h200; // 512 bits
  localparam logic [FCNT_W-1:0] PER_8192 = 11'h400; // 1024 bits

  // time slots per frame: rate divided by 64 khz
  localparam logic [7:0] NSLOT_NONE = 8'h00;
  localparam logic [7:0] NSLOT_1M5 = 8'h18; // 24
  localparam logic [7:0] NSLOT_2M = 8'h20; // 32
  localparam logic [7:0] NSLOT_4M = 8'h40; // 64
  localparam logic [7:0] NSLOT_8M = 8'h80; // 128

  // bits in a slot, msb first
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] PCM_RST = 8'h00;

  // mode-select encodings, {high, low}
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h2;

  // detected master clock rate
  typedef enum logic [2:0] {
    RATE_NONE,
    RATE_1M5,
    RATE_2M,
    RATE_4M,
    RATE_8M
  } rate_t;

  // per-channel time slot assignment
  typedef struct packed {
    logic tx_en;
    logic [6:0] tx_slot;
    logic rx_en;
    logic [6:0] rx_slot;
  } chan_cfg_t;

  // frame start shift in bit clocks, 0..7 per direction
  typedef struct packed {
    logic [2:0] tx_shift;
    logic [2:0] rx_shift;
  } frame_offset_t;

  // position inside a shifted frame
  typedef struct packed {
    logic valid;
    logic [7:0] slot;
    logic [2:0] bit_idx;
  } slot_pos_t;

  localparam chan_cfg_t CFG_RST = '0;
  localparam frame_offset_t OFFSET_RST = '0;

endpackage

// ===== pcm_highway_port_a.sv
// pcm highway port a: frame timing, rate detection, tx slot drive, rx slot capture
// assumes frame_sync_in and rx_serial_in_a are synchronous to mclk, and the
// backplane resolves the open-drain strobe and tristate data from their enables
`timescale 1ns/1ps

// Overview of operation
// - mode pins 00 hold the port in reset; 10 runs it normally.
// - frame start shifts 0 to 7 bit clocks, tx and rx set apart.
// - master clock rate found alone: 1.536/1.544, 2.048, 4.096, 8.192 mhz.
// - master clock itself is the bit clock for all shifting.
// - tx data high-z outside own slots; bits change on rising edges.
// - rx data ignored outside own slots; bits sampled on falling edges.
// - tx slot strobe pulled low exactly while tx data is driven.
// - tx data stays high-z while in reset.
// - no slot assigned after reset until software programs one.
module pcm_highway_port_a (
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // mode select pins
  input wire logic mode_select_high,
  input wire logic mode_select_low,
  // highway pins
  input wire logic frame_sync_in,
  input wire logic rx_serial_in_a,
  output logic tx_serial_out_a,
  output logic tx_serial_out_a_oe_n,
  input wire logic tx_slot_strobe_a_n_in,
  output logic tx_slot_strobe_a_n_out,
  output logic tx_slot_strobe_a_n_oe_n,
  // slot programming from the control side
  input wire logic cfg_load,
  input wire pcm_port_pkg::chan_cfg_t [pcm_port_pkg::NUM_CH-1:0] cfg_in,
  input wire pcm_port_pkg::frame_offset_t frame_offset_setting,
  // channel data
  input wire logic [pcm_port_pkg::NUM_CH-1:0][7:0] tx_pcm,
  output logic [pcm_port_pkg::NUM_CH-1:0][7:0] rx_pcm,
  output logic [pcm_port_pkg::NUM_CH-1:0] rx_valid,
  // status
  output pcm_port_pkg::rate_t rate,
  output logic held_in_reset
);
  import pcm_port_pkg::*;

  logic hold;
  logic fs_q;
  logic fs_rise;
  logic seen_q;
  logic [FCNT_W-1:0] fcnt_q;
  logic [FCNT_W-1:0] fcnt_d;
  logic [7:0] nslot_q;
  rate_t rate_q;
  chan_cfg_t [NUM_CH-1:0] cfg_q;
  frame_offset_t off_q;
  slot_pos_t tx_pos;
  slot_pos_t rx_pos;
  logic tx_hit;
  logic [1:0] tx_ch;
  logic rx_hit;
  logic [1:0] rx_ch;
  logic tx_bit_q;
  logic tx_drive_q;
  logic [7:0] rx_sh_q;
  logic rx_last_q;
  logic [1:0] rx_ch_q;

  // position of a frame bit after the programmed shift, invalid past the last slot
  function automatic slot_pos_t locate(input logic [FCNT_W-1:0] cnt, input logic [2:0] shift,
                                       input logic [7:0] nslot);
    logic [FCNT_W-1:0] p;
    slot_pos_t r;
    p = cnt - {{(FCNT_W-3){1'b0}}, shift};
    r.bit_idx = p[2:0];
    r.slot = {1'b0, p[9:3]};
    r.valid = (cnt >= {{(FCNT_W-3){1'b0}}, shift}) && (p[FCNT_W-1] == 1'b0) && (r.slot < nslot);
    return r;
  endfunction

  // map a measured frame length to a rate, unknown lengths give no rate
  function automatic rate_t classify(input logic [FCNT_W-1:0] per);
    rate_t r;
    r = RATE_NONE;
    if (per == PER_1536 || per == PER_1544) begin
      r = RATE_1M5;
    end else if (per == PER_2048) begin
      r = RATE_2M;
    end else if (per == PER_4096) begin
      r = RATE_4M;
    end else if (per == PER_8192) begin
      r = RATE_8M;
    end
    return r;
  endfunction

  // only 10 runs; 01 and 11 are unused codes, so they are simply held too
  assign hold = rst || ({mode_select_high, mode_select_low} != MODE_NORMAL);
  assign held_in_reset = hold;

  // one sync edge opens both directions' frames
  assign fs_rise = frame_sync_in && !fs_q;

  // frame bit counter, saturating so a missing sync cannot wrap into slots
  always_comb begin
    if (fs_rise) begin
      fcnt_d = FCNT_RST;
    end else if (fcnt_q == FCNT_MAX) begin
      fcnt_d = fcnt_q;
    end else begin
      fcnt_d = fcnt_q + 11'h001;
    end
  end

  always_ff @(posedge mclk) begin
    if (hold) begin
      fs_q <= 1'b0;
      fcnt_q <= FCNT_MAX;
    end else begin
      fs_q <= frame_sync_in;
      fcnt_q <= fcnt_d;
    end
  end

  // rate detection: measure bit clocks between sync edges, no software setting
  always_ff @(posedge mclk) begin
    if (hold) begin
      seen_q <= 1'b0;
      rate_q <= RATE_NONE;
      nslot_q <= NSLOT_NONE;
    end else if (fs_rise) begin
      seen_q <= 1'b1;
      // first edge after reset has no prior edge to measure from
      if (seen_q) begin
        rate_q <= classify(fcnt_q + 11'h001);
        unique case (classify(fcnt_q + 11'h001))
          RATE_1M5: nslot_q <= NSLOT_1M5;
          RATE_2M: nslot_q <= NSLOT_2M;
          RATE_4M: nslot_q <= NSLOT_4M;
          RATE_8M: nslot_q <= NSLOT_8M;
          RATE_NONE: nslot_q <= NSLOT_NONE;
        endcase
      end
    end
  end
  assign rate = rate_q;

  // slot programming, wiped by reset so nothing is assigned until loaded
  always_ff @(posedge mclk) begin
    if (hold) begin
      cfg_q <= {NUM_CH{CFG_RST}};
      off_q <= OFFSET_RST;
    end else if (cfg_load) begin
      cfg_q <= cfg_in;
      off_q <= frame_offset_setting;
    end
  end

  // tx looks one bit ahead so the registered pin changes on the rising edge
  assign tx_pos = locate(fcnt_d, off_q.tx_shift, nslot_q);
  // rx judges the bit now on the line, sampled at the coming falling edge
  assign rx_pos = locate(fcnt_q, off_q.rx_shift, nslot_q);

  // channel owning the current slot, lowest channel wins a double assignment
  always_comb begin
    tx_hit = 1'b0;
    tx_ch = 2'h0;
    rx_hit = 1'b0;
    rx_ch = 2'h0;
    for (int c = NUM_CH - 1; c >= 0; c--) begin
      if (tx_pos.valid && cfg_q[c].tx_en && ({1'b0, cfg_q[c].tx_slot} == tx_pos.slot)) begin
        tx_hit = 1'b1;
        tx_ch = 2'(c);
      end
      if (rx_pos.valid && cfg_q[c].rx_en && ({1'b0, cfg_q[c].rx_slot} == rx_pos.slot)) begin
        rx_hit = 1'b1;
        rx_ch = 2'(c);
      end
    end
  end

  // transmit driver: one byte msb first, only inside an owned slot
  always_ff @(posedge mclk) begin
    if (hold) begin
      tx_drive_q <= 1'b0;
      tx_bit_q <= 1'b0;
    end else begin
      tx_drive_q <= tx_hit;
      tx_bit_q <= tx_pcm[tx_ch][LAST_BIT - tx_pos.bit_idx];
    end
  end

  assign tx_serial_out_a = tx_bit_q;
  assign tx_serial_out_a_oe_n = !tx_drive_q;
  // strobe shares the data enable flop, so the two spans are identical
  assign tx_slot_strobe_a_n_out = 1'b0;
  assign tx_slot_strobe_a_n_oe_n = !tx_drive_q;

  // receive shifter on the falling edge, untouched outside owned slots
  always_ff @(negedge mclk) begin
    if (hold) begin
      rx_sh_q <= PCM_RST;
      rx_last_q <= 1'b0;
      rx_ch_q <= 2'h0;
    end else begin
      rx_last_q <= rx_hit && (rx_pos.bit_idx == LAST_BIT);
      if (rx_hit) begin
        rx_sh_q <= {rx_sh_q[6:0], rx_serial_in_a};
        rx_ch_q <= rx_ch;
      end
    end
  end

  // hand the finished byte to the rising-edge domain; the flag spans one full period
  always_ff @(posedge mclk) begin
    if (hold) begin
      rx_pcm <= {NUM_CH{PCM_RST}};
      rx_valid <= '0;
    end else begin
      rx_valid <= '0;
      if (rx_last_q) begin
        rx_pcm[rx_ch_q] <= rx_sh_q;
        rx_valid[rx_ch_q] <= 1'b1;
      end
    end
  end

  // pin readback is not needed: the strobe is only ever pulled low by us
  logic unused_strobe_in;
  assign unused_strobe_in = tx_slot_strobe_a_n_in;

endmodule

// ===== pcm_highway_port_a_properties.sv
// pin-level checks for pcm highway port a, attached by bind
// assumes rst is synchronous on mclk and the mode pins are levels
`timescale 1ns/1ps
module pcm_highway_port_a_properties
  import pcm_port_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic rst,
  // pins
  input wire logic mode_select_high,
  input wire logic mode_select_low,
  input wire logic frame_sync_in,
  input wire logic tx_serial_out_a_oe_n,
  input wire logic tx_slot_strobe_a_n_out,
  input wire logic tx_slot_strobe_a_n_oe_n,
  // status and data
  input wire logic [NUM_CH-1:0][7:0] rx_pcm,
  input wire logic [NUM_CH-1:0] rx_valid,
  input wire rate_t rate,
  input wire logic held_in_reset
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // a slot is eight bits long unless a hold cuts it short
  sequence s_slot;
    (!tx_serial_out_a_oe_n || held_in_reset) [*8];
  endsequence
  // rate is seen one edge after the design first samples the sync high
  sequence s_sync_rise;
    $past(frame_sync_in) && !$past(frame_sync_in, 2);
  endsequence
  a_mode_hold: assert property (held_in_reset == ({mode_select_high, mode_select_low} != MODE_NORMAL))
    else $error("hold does not follow mode pins");
  a_hold_floats: assert property (held_in_reset |=> tx_serial_out_a_oe_n && rx_valid == '0)
    else $error("port active while held");
  a_strobe_tracks: assert property (tx_slot_strobe_a_n_oe_n == tx_serial_out_a_oe_n && !tx_slot_strobe_a_n_out)
    else $error("strobe differs from tx drive");
  a_slot_whole: assert property ($fell(tx_serial_out_a_oe_n) |-> s_slot)
    else $error("tx slot shorter than eight bits");
  a_needs_rate: assert property ((!tx_serial_out_a_oe_n || rx_valid != '0) |-> rate != RATE_NONE)
    else $error("slot activity without a rate");
  a_rate_on_sync: assert property ($changed(rate) && !$past(held_in_reset) |-> s_sync_rise)
    else $error("rate changed away from a sync");
  a_rx_with_valid: assert property ($changed(rx_pcm) && !$past(held_in_reset) |-> rx_valid != '0)
    else $error("rx byte changed without valid");
  a_valid_pulse: assert property ((rx_valid & $past(rx_valid)) == '0)
    else $error("rx valid longer than one cycle");
endmodule

bind pcm_highway_port_a pcm_highway_port_a_properties u_props (.mclk(mclk), .rst(rst),
  .mode_select_high(mode_select_high), .mode_select_low(mode_select_low), .frame_sync_in(frame_sync_in),
  .tx_serial_out_a_oe_n(tx_serial_out_a_oe_n), .tx_slot_strobe_a_n_out(tx_slot_strobe_a_n_out),
  .tx_slot_strobe_a_n_oe_n(tx_slot_strobe_a_n_oe_n), .rx_pcm(rx_pcm), .rx_valid(rx_valid), .rate(rate),
  .held_in_reset(held_in_reset));

// ===== highway_master.sv
// highway master model: frame sync and rx line for port a
// assumes launches 1 ns after each rising mclk edge
`timescale 1ns/1ps
module highway_master (
  // clock
  input wire logic mclk,
  // frame setup
  input wire logic [10:0] period,
  input wire logic [10:0] rx_start,
  input wire logic [7:0] rx_byte,
  // highway
  output logic frame_sync_in,
  output logic rx_serial_in_a,
  output logic [10:0] bit_pos
);
  int k;
  initial begin
    bit_pos = 11'h000;
    frame_sync_in = 1'b0;
    rx_serial_in_a = 1'b0;
  end
  // one wide sync per period; raw bit n sits at bit_pos n+2
  always @(posedge mclk) begin
    #1;
    bit_pos = (bit_pos + 11'h001 >= period) ? 11'h000 : bit_pos + 11'h001;
    frame_sync_in = (bit_pos > 11'h000 && bit_pos < 11'h005);
    k = int'(bit_pos) - 2 - int'(rx_start);
    // toggles outside the byte so a stray sample shows
    rx_serial_in_a = (k >= 0 && k < 8) ? rx_byte[7 - k] : ~rx_serial_in_a;
  end
endmodule

// ===== pcm_highway_port_a_test.sv
// self-checking bench for pcm highway port a
// assumes the checker is bound in and the master model drives sync and rx
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("[FAIL] %0t %s", $time, m); end end
module pcm_highway_port_a_test;
  import pcm_port_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, mode_select_high = 1'b0, mode_select_low = 1'b0, cfg_load = 1'b0;
  chan_cfg_t [NUM_CH-1:0] cfg_in = '0;
  frame_offset_t frame_offset_setting = OFFSET_RST;
  logic [NUM_CH-1:0][7:0] tx_pcm = 32'h3c5ac396, rx_pcm;
  logic [NUM_CH-1:0] rx_valid;
  logic [10:0] period = PER_2048, bit_pos;
  logic frame_sync_in, rx_serial_in_a, tx_serial_out_a, tx_oe_n, str_out, str_oe_n, held_in_reset;
  rate_t rate;
  int num_errors = 0, n_checks = 0, lows;
  wire logic str_wire = str_oe_n ? 1'b1 : str_out; // pull-up on the strobe
  always #50 mclk = ~mclk;
  highway_master u_highway_master (.mclk(mclk), .period(period), .rx_start(11'h00d), .rx_byte(8'ha6),
    .frame_sync_in(frame_sync_in), .rx_serial_in_a(rx_serial_in_a), .bit_pos(bit_pos));
  pcm_highway_port_a u_pcm_highway_port_a (.mclk(mclk), .rst(rst), .mode_select_high(mode_select_high),
    .mode_select_low(mode_select_low), .frame_sync_in(frame_sync_in), .rx_serial_in_a(rx_serial_in_a),
    .tx_serial_out_a(tx_serial_out_a), .tx_serial_out_a_oe_n(tx_oe_n), .tx_slot_strobe_a_n_in(str_wire),
    .tx_slot_strobe_a_n_out(str_out), .tx_slot_strobe_a_n_oe_n(str_oe_n), .cfg_load(cfg_load),
    .cfg_in(cfg_in), .frame_offset_setting(frame_offset_setting), .tx_pcm(tx_pcm), .rx_pcm(rx_pcm),
    .rx_valid(rx_valid), .rate(rate), .held_in_reset(held_in_reset));
  task tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask
  task wait_pos(input logic [10:0] p);
    for (int i = 0; i < 2100 && bit_pos !== p; i++) tick(1);
    `CHK(bit_pos, p, "bit position never reached")
  endtask
  // a silent port shows no driven cycle in the stretch
  task count_lows(input int n);
    lows = 0;
    repeat (n) begin
      tick(1);
      lows += (tx_oe_n !== 1'b1);
    end
  endtask
  task set_mode(input logic [1:0] m, input int n);
    {mode_select_high, mode_select_low} = m;
    tick(n);
  endtask
  task t_reset;
    tick(8);
    `CHK({held_in_reset, tx_oe_n, str_wire, rate}, {3'b111, RATE_NONE}, "pins float in reset")
    rst = 1'b0;
    set_mode(MODE_NORMAL, 1);
    `CHK(held_in_reset, 1'b0, "runs in mode 10")
  endtask
  task t_rates;
    logic [10:0] per [6] = '{PER_1536, PER_1544, PER_2048, PER_4096, PER_8192, 11'h12c};
    rate_t exp [6] = '{RATE_1M5, RATE_1M5, RATE_2M, RATE_4M, RATE_8M, RATE_NONE};
    for (int i = 0; i < 6; i++) begin
      period = per[i];
      tick(3 * per[i]);
      `CHK(rate, exp[i], "detected rate")
    end
    period = PER_2048;
    count_lows(600);
    `CHK(lows, 0, "drive before programming")
  endtask
  // tx slot 2 shift 3 on ch 1, rx slot 1 shift 5 on ch 2
  task t_slots;
    cfg_in[1] = 16'h8200;
    cfg_in[2] = 16'h0081;
    frame_offset_setting = 6'h1d;
    cfg_load = 1'b1;
    tick(1);
    cfg_load = 1'b0;
    wait_pos(11'h013);
    for (int c = 19; c < 31; c++) begin
      `CHK({tx_oe_n, str_wire}, {2{!(c > 20 && c < 29)}}, "tx drive window")
      if (c > 20 && c < 29) `CHK(tx_serial_out_a, tx_pcm[1][28 - c], "tx bit")
      tick(1);
    end
    wait_pos(11'h000);
    for (int i = 0; i < 300 && rx_valid !== 4'h4; i++) tick(1);
    `CHK({bit_pos, rx_valid, rx_pcm[2], rx_pcm[0]}, {11'h017, 4'h4, 8'ha6, 8'h00}, "rx byte")
  endtask
  // illegal mode codes mid-slot act as a hold
  task t_hold;
    wait_pos(11'h016);
    set_mode(2'h1, 4);
    `CHK({held_in_reset, tx_oe_n, rx_valid, rx_pcm[2], rate}, {6'h30, 8'h00, RATE_NONE}, "mode 01")
    set_mode(2'h3, 4);
    `CHK({held_in_reset, tx_oe_n}, 2'b11, "mode 11 holds")
    set_mode(MODE_NORMAL, 1);
    count_lows(1200);
    `CHK({lows, rate}, {32'h0, RATE_2M}, "slots cleared by hold")
  endtask
  task final_report;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    t_reset;
    t_rates;
    t_slots;
    t_hold;
    final_report;
  end
  // watchdog: the sequence needs about 1 ms
  initial begin
    #3000000;
    num_errors++;
    final_report;
  end
endmodule
